// >>> src/lpt_pkg.sv
// lpt_pkg: timing constants and command encodings for the maintenance sequencer
package lpt_pkg;

   // clock period in picoseconds (125 MHz)
   localparam int unsigned CLK_PS = 8000;

   // least time in ps and in clocks, rounded up, never below the nCK floor
   function automatic int unsigned cyc_max(input int unsigned t_ps, input int unsigned nck);
      int unsigned c;
      c = (t_ps + CLK_PS - 1) / CLK_PS;
      if (c < nck) c = nck;
      if (c < 1) c = 1;
      return c;
   endfunction

   // timing figures in ps, as printed
   localparam int unsigned T_XP_PS      = 7500;
   localparam int unsigned T_CKE_PS     = 7500;
   localparam int unsigned T_CMDCKE_PS  = 1750;
   localparam int unsigned T_CKELCK_PS  = 5000;
   localparam int unsigned T_CSCKE_PS   = 1750;
   localparam int unsigned T_MRWCKEL_PS = 14000;
   localparam int unsigned T_ZQCKE_PS   = 1750;
   localparam int unsigned T_ZQCAL_PS   = 1000000;
   localparam int unsigned T_ZQLAT_PS   = 30000;
   localparam int unsigned T_ZQRST_PS   = 50000;
   localparam int unsigned T_OSCO_PS    = 40000;
   localparam int unsigned T_FC_SM_PS   = 200000;
   localparam int unsigned T_FC_LG_PS   = 250000;
   localparam int unsigned T_CKFSP_PS   = 7500;
   localparam int unsigned T_DQSCKE_PS  = 10000;
   localparam int unsigned T_CAENT_PS   = 250000;
   localparam int unsigned T_CACD_PS    = 110000;

   // cycle counts
   localparam int unsigned C_XP      = cyc_max(T_XP_PS, 5);
   localparam int unsigned C_CKE     = cyc_max(T_CKE_PS, 4);
   localparam int unsigned C_CMDCKE  = cyc_max(T_CMDCKE_PS, 3);
   localparam int unsigned C_CKELCK  = cyc_max(T_CKELCK_PS, 5);
   localparam int unsigned C_CSCKE   = cyc_max(T_CSCKE_PS, 1);
   localparam int unsigned C_MRWCKEL = cyc_max(T_MRWCKEL_PS, 10);
   localparam int unsigned C_ZQCKE   = cyc_max(T_ZQCKE_PS, 3);
   localparam int unsigned C_ZQCAL   = cyc_max(T_ZQCAL_PS, 1);
   localparam int unsigned C_ZQLAT   = cyc_max(T_ZQLAT_PS, 8);
   localparam int unsigned C_ZQRST   = cyc_max(T_ZQRST_PS, 3);
   localparam int unsigned C_OSCO    = cyc_max(T_OSCO_PS, 8);
   localparam int unsigned C_FC_SM   = cyc_max(T_FC_SM_PS, 1);
   localparam int unsigned C_FC_LG   = cyc_max(T_FC_LG_PS, 1);
   localparam int unsigned C_CKFSP   = cyc_max(T_CKFSP_PS, 4);
   localparam int unsigned C_DQSCKE  = cyc_max(T_DQSCKE_PS, 1);
   localparam int unsigned C_CAENT   = cyc_max(T_CAENT_PS, 1);
   localparam int unsigned C_CACD    = cyc_max(T_CACD_PS, 4);
   localparam int unsigned C_XCBT_SM = cyc_max(T_FC_SM_PS, 5);
   localparam int unsigned C_XCBT_LG = cyc_max(T_FC_LG_PS, 5);
   localparam int unsigned C_WLDQSEN = 20;
   localparam int unsigned C_WLWPRE  = 20;
   localparam int unsigned C_WLMRD   = 40;
   localparam int unsigned C_CKDQS   = cyc_max(T_CKFSP_PS, 4);

   localparam int CNT_W = 8;

   // command codes on the request port
   localparam logic [3:0] OP_NOP      = 4'h0;
   localparam logic [3:0] OP_PD_ENTER = 4'h1;
   localparam logic [3:0] OP_PD_EXIT  = 4'h2;
   localparam logic [3:0] OP_MRW      = 4'h3;
   localparam logic [3:0] OP_ZQ_START = 4'h4;
   localparam logic [3:0] OP_ZQ_LATCH = 4'h5;
   localparam logic [3:0] OP_ZQ_RESET = 4'h6;
   localparam logic [3:0] OP_OSC_STOP = 4'h7;
   localparam logic [3:0] OP_OSC_READ = 4'h8;
   localparam logic [3:0] OP_OSC_START= 4'h9;
   localparam logic [3:0] OP_FSP      = 4'ha;
   localparam logic [3:0] OP_WL_ENTER = 4'hb;
   localparam logic [3:0] OP_CBT_ENTER= 4'hc;
   localparam logic [3:0] OP_CBT_CMD  = 4'hd;
   localparam logic [3:0] OP_CBT_EXIT = 4'he;
   localparam logic [3:0] OP_CMD      = 4'hf;

endpackage

// >>> src/lpt_dly.sv
// lpt_dly: loadable down-counter that reports expiry of a minimum delay
`timescale 1ns/1ns
module lpt_dly
   import lpt_pkg::*;
#(
   parameter int W = 8
) (
   // clock and reset
   input  wire logic         core_clk,
   input  wire logic         rst,
   // load
   input  wire logic         load,
   input  wire logic [W-1:0] value,
   // status
   output logic              done
);
   logic [W-1:0] count;

   assign done = (count == '0);

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         count <= '0;
      end else if (load) begin
         count <= value;
      end else if (!done) begin
         count <= count - 1'b1;
      end
   end
endmodule

// >>> src/lpt_sync.sv
// lpt_sync: two-stage synchroniser for the write leveling feedback pin
`timescale 1ns/1ns
module lpt_sync (
   // clock and reset
   input  wire logic core_clk,
   input  wire logic rst,
   // pin and result
   input  wire logic din,
   output logic      dout
);
   logic meta;

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         meta <= 1'b0;
         dout <= 1'b0;
      end else begin
         meta <= din;
         dout <= meta;
      end
   end
endmodule

// >>> src/lpt_ctrl.sv
// lpt_ctrl: host sequencer for power-down, calibration and training timing
`timescale 1ns/1ns
module lpt_ctrl
   import lpt_pkg::*;
#(
   parameter int unsigned ZQCAL_CYCLES = C_ZQCAL
) (
   // clock and reset
   input  wire logic        core_clk,
   input  wire logic        rst,
   // request port
   input  wire logic        req_valid,
   input  wire logic [3:0]  req_op,
   input  wire logic        req_long,
   input  wire logic [5:0]  req_ca,
   output logic             req_ready,
   // device pins
   output logic             ck_en,
   output logic             cke,
   output logic             cs,
   output logic [5:0]       ca,
   output logic             dqs_t,
   output logic             dqs_c,
   output logic             dqs_oe,
   input  wire logic        wl_fb,
   // status
   output logic             wl_sample,
   output logic             wl_sample_valid,
   output logic             in_pd,
   output logic             in_cbt
);
   // ---------------------------------------------
   // state
   // ---------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_CMD,
      ST_DQS_PRE,
      ST_CKE_LOW,
      ST_WL_WAIT,
      ST_WL_PRE,
      ST_WL_TOG,
      ST_WL_POST
   } lpt_state_t;

   lpt_state_t       state;
   lpt_state_t       next_state;
   logic [3:0]       cur_op;
   logic [3:0]       last_cmd;
   logic             wl_prev;
   logic [2:0]       cap_dly;
   logic             wl_sync;
   logic             zq_run;
   logic             sel_long;
   logic [CNT_W-1:0] step_cnt;

   // ---------------------------------------------
   // delay counters
   // ---------------------------------------------
   // cmd: gate on next command; cke: min pulse; clk: valid clock hold;
   // zq: calibration window; osc: readout hold; step: local sequencing
   logic             cmd_load, cke_load, clk_load, zq_load, osc_load, step_load;
   logic [CNT_W-1:0] cmd_val, clk_val, step_val;
   logic [CNT_W-1:0] cke_val, osc_val;
   logic [17:0]      zq_val;
   logic             cmd_done, cke_done, clk_done, zq_done, osc_done, step_done;

   function automatic logic [CNT_W-1:0] cv(input int unsigned c);
      return CNT_W'(c);
   endfunction

   lpt_dly #(.W(CNT_W)) u_cmd  (.core_clk(core_clk), .rst(rst), .load(cmd_load),
                                .value(cmd_val), .done(cmd_done));
   lpt_dly #(.W(CNT_W)) u_cke  (.core_clk(core_clk), .rst(rst), .load(cke_load),
                                .value(cke_val), .done(cke_done));
   lpt_dly #(.W(CNT_W)) u_clk  (.core_clk(core_clk), .rst(rst), .load(clk_load),
                                .value(clk_val), .done(clk_done));
   lpt_dly #(.W(18))    u_zq   (.core_clk(core_clk), .rst(rst), .load(zq_load),
                                .value(zq_val), .done(zq_done));
   lpt_dly #(.W(CNT_W)) u_osc  (.core_clk(core_clk), .rst(rst), .load(osc_load),
                                .value(osc_val), .done(osc_done));
   lpt_dly #(.W(CNT_W)) u_step (.core_clk(core_clk), .rst(rst), .load(step_load),
                                .value(step_val), .done(step_done));

   lpt_sync u_wl_sync (.core_clk(core_clk), .rst(rst), .din(wl_fb), .dout(wl_sync));

   // ---------------------------------------------
   // acceptance decode
   // ---------------------------------------------
   wire is_pd_enter = (req_op == OP_PD_ENTER) || (req_op == OP_CBT_ENTER);
   wire is_pd_exit  = (req_op == OP_PD_EXIT) || (req_op == OP_CBT_EXIT);
   // latch and read also wait for the calibration window and oscillator hold
   wire zq_ok   = (req_op != OP_ZQ_LATCH) || (zq_done && zq_run);
   wire osc_ok  = ((req_op != OP_OSC_READ) && (req_op != OP_OSC_START)) || osc_done;
   // entry into low CKE needs the command spacing and the high pulse width
   wire enter_ok = !is_pd_enter || (!in_pd && cke_done && step_done);
   wire exit_ok  = !is_pd_exit || (in_pd && cke_done && clk_done);
   wire cbt_ok   = (req_op != OP_CBT_CMD) || in_cbt;
   wire other_ok = is_pd_exit || req_op == OP_CBT_CMD || !in_pd;
   wire go       = req_valid && req_ready;

   // counters all zero means every max(time,clocks) term has passed
   assign req_ready = (state == ST_IDLE) && cmd_done && zq_ok && osc_ok && enter_ok
                      && exit_ok && cbt_ok && other_ok;

   // ---------------------------------------------
   // next state
   // ---------------------------------------------
   always_comb begin
      next_state = state;
      unique case (state)
         ST_IDLE: begin
            if (go && req_op == OP_CBT_ENTER) begin
               next_state = ST_DQS_PRE;
            end else if (go && req_op == OP_PD_ENTER) begin
               next_state = ST_CKE_LOW;
            end else if (go && req_op == OP_WL_ENTER) begin
               next_state = ST_WL_WAIT;
            end else if (go && !is_pd_exit && req_op != OP_NOP) begin
               next_state = ST_CMD;
            end
         end
         ST_CMD:     next_state = ST_IDLE;
         ST_DQS_PRE: if (step_done) next_state = ST_CKE_LOW;
         ST_CKE_LOW: next_state = ST_IDLE;
         ST_WL_WAIT: if (step_done) next_state = ST_WL_PRE;
         ST_WL_PRE:  if (step_done) next_state = ST_WL_TOG;
         ST_WL_TOG:  if (step_cnt == '0) next_state = ST_WL_POST;
         ST_WL_POST: if (step_done) next_state = ST_IDLE;
      endcase
   end

   // ---------------------------------------------
   // counter loads
   // ---------------------------------------------
   assign cke_load = (state == ST_CKE_LOW) || (go && is_pd_exit);
   assign cke_val  = cv(C_CKE);
   assign clk_load = (state == ST_CKE_LOW);
   // low CKE holds clock and CS longest of plain, after-MRW and after-ZQ figures
   assign clk_val  = (last_cmd == OP_MRW) ? cv(C_MRWCKEL) :
                     (last_cmd == OP_ZQ_START && C_ZQCKE > C_CKELCK) ? cv(C_ZQCKE) :
                     cv(C_CKELCK);
   assign zq_load  = go && (req_op == OP_ZQ_START);
   assign zq_val   = 18'(ZQCAL_CYCLES);
   assign osc_load = go && (req_op == OP_OSC_STOP);
   assign osc_val  = cv(C_OSCO);

   always_comb begin
      cmd_load = 1'b0;
      cmd_val  = '0;
      if (state == ST_CKE_LOW && cur_op == OP_CBT_ENTER) begin
         cmd_load = 1'b1;
         cmd_val  = cv(C_CAENT);
      end else if (go) begin
         cmd_load = 1'b1;
         unique case (req_op)
            OP_PD_EXIT:  cmd_val = cv(C_XP);
            OP_CBT_EXIT: cmd_val = sel_xcbt_long(req_long);
            OP_CBT_CMD:  cmd_val = cv(C_CACD);
            OP_ZQ_LATCH: cmd_val = cv(C_ZQLAT);
            OP_ZQ_RESET: cmd_val = cv(C_ZQRST);
            OP_FSP:      cmd_val = req_long ? cv(C_FC_LG) : cv(C_FC_SM);
            default:     cmd_val = '0;
         endcase
      end
   end

   function automatic logic [CNT_W-1:0] sel_xcbt_long(input logic lng);
      return lng ? cv(C_XCBT_LG) : cv(C_XCBT_SM);
   endfunction

   always_comb begin
      step_load = 1'b0;
      step_val  = '0;
      if (go && req_op == OP_CBT_ENTER) begin
         step_load = 1'b1;
         step_val  = cv(C_DQSCKE);
      end else if (go && req_op == OP_WL_ENTER) begin
         step_load = 1'b1;
         step_val  = cv(C_WLDQSEN);
      end else if (state == ST_WL_WAIT && step_done) begin
         step_load = 1'b1;
         step_val  = cv(C_WLMRD - C_WLDQSEN);
      end else if (state == ST_WL_TOG && step_cnt == '0) begin
         step_load = 1'b1;
         step_val  = cv(C_CKDQS);
      end else if (go && !is_pd_enter) begin
         step_load = 1'b1;
         step_val  = cv(C_CMDCKE);
      end
   end

   // ---------------------------------------------
   // registers
   // ---------------------------------------------
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         state    <= ST_IDLE;
         cur_op   <= OP_NOP;
         last_cmd <= OP_NOP;
         sel_long <= 1'b0;
      end else begin
         state <= next_state;
         if (go) begin
            cur_op   <= req_op;
            sel_long <= req_long;
            if (!is_pd_enter && !is_pd_exit) last_cmd <= req_op;
         end
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         cke    <= 1'b1;
         in_pd  <= 1'b0;
         in_cbt <= 1'b0;
      end else if (state == ST_CKE_LOW) begin
         cke    <= 1'b0;
         in_pd  <= 1'b1;
         in_cbt <= (cur_op == OP_CBT_ENTER);
      end else if (go && is_pd_exit) begin
         cke    <= 1'b1;
         in_pd  <= 1'b0;
         in_cbt <= 1'b0;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         zq_run <= 1'b0;
      end else if (go && req_op == OP_ZQ_START) begin
         zq_run <= 1'b1;
      end else if (go && req_op == OP_ZQ_LATCH) begin
         zq_run <= 1'b0;
      end
   end

   // command strobe: CS high one cycle with the CA word; held low otherwise
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         cs <= 1'b0;
         ca <= '0;
      end else begin
         cs <= (next_state == ST_CMD) || (state == ST_IDLE && go && req_op == OP_CBT_CMD);
         ca <= (go) ? req_ca : ca;
      end
   end

   // clock kept running except while parked in power-down outside training with hold expired
   assign ck_en = !(in_pd && !in_cbt && clk_done && state == ST_IDLE) || !cke_done;

   // ---------------------------------------------
   // strobe drive
   // ---------------------------------------------
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         step_cnt <= '0;
         dqs_t    <= 1'b0;
         dqs_c    <= 1'b1;
         dqs_oe   <= 1'b0;
      end else begin
         unique case (state)
            ST_DQS_PRE: begin
               dqs_oe <= 1'b1;
               dqs_t  <= 1'b0;
               dqs_c  <= 1'b1;
            end
            ST_WL_PRE: begin
               dqs_oe   <= 1'b1;
               dqs_t    <= 1'b0;
               dqs_c    <= 1'b1;
               step_cnt <= cv(C_CKDQS);
            end
            ST_WL_TOG: begin
               dqs_t    <= ~dqs_t;
               dqs_c    <= ~dqs_c;
               step_cnt <= step_cnt - 1'b1;
            end
            ST_WL_POST: begin
               dqs_t <= 1'b0;
               dqs_c <= 1'b1;
               if (step_done) dqs_oe <= 1'b0;
            end
            default: begin
               if (!in_cbt) dqs_oe <= 1'b0;
            end
         endcase
      end
   end

   // capture four clocks after the strobe fall: an answer up to 20ns late
   // must have crossed both synchroniser stages before it is taken
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         wl_prev         <= 1'b0;
         cap_dly         <= 3'h0;
         wl_sample       <= 1'b0;
         wl_sample_valid <= 1'b0;
      end else begin
         wl_prev         <= dqs_t;
         cap_dly         <= {cap_dly[1:0], (state == ST_WL_TOG) && wl_prev && !dqs_t};
         wl_sample_valid <= cap_dly[2];
         if (cap_dly[2]) wl_sample <= wl_sync;
      end
   end
endmodule

// >>> test/lpt_ctrl_sva.sv
// lpt_ctrl_sva: pin timing checks for the maintenance sequencer
`timescale 1ns/1ns
module lpt_ctrl_sva
   import lpt_pkg::*;
#(
   parameter int unsigned ZQCAL_CYCLES = C_ZQCAL
) (
   // clock and reset
   input wire logic       core_clk,
   input wire logic       rst,
   // request port
   input wire logic       req_valid,
   input wire logic [3:0] req_op,
   input wire logic       req_long,
   input wire logic [5:0] req_ca,
   input wire logic       req_ready,
   // device pins
   input wire logic       ck_en,
   input wire logic       cke,
   input wire logic       cs,
   input wire logic [5:0] ca,
   input wire logic       dqs_t,
   input wire logic       dqs_c,
   input wire logic       dqs_oe,
   input wire logic       wl_fb,
   // status
   input wire logic       wl_sample,
   input wire logic       wl_sample_valid,
   input wire logic       in_pd,
   input wire logic       in_cbt
);
   // ----------------------------------------
   // helper counters
   // ----------------------------------------
   // spans beyond eight cycles are counted here, not unrolled
   wire        take = req_valid && req_ready;
   logic [3:0] cbt_cnt;
   logic [5:0] wl_cnt;
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         cbt_cnt <= 4'h0;
         wl_cnt  <= 6'h00;
      end else begin
         cbt_cnt <= (take && req_op == OP_CBT_CMD) ? 4'hd : cbt_cnt - {3'h0, cbt_cnt != 4'h0};
         wl_cnt  <= (take && req_op == OP_WL_ENTER) ? 6'h28 : wl_cnt - {5'h00, wl_cnt != 6'h00};
      end
   end
   // ----------------------------------------
   // assertions
   // ----------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   a_cke_low_min: assert property ($fell(cke) |-> (!cke) [*4])
      else $error("cke low pulse too short");
   a_cke_high_min: assert property ($rose(cke) |-> cke [*4])
      else $error("cke high pulse too short");
   a_exit_cmd_gap: assert property ($rose(cke) |-> (!cs) [*5])
      else $error("command too soon after cke rise");
   a_cmd_to_cke: assert property ($fell(cke) |-> !cs && !$past(cs) && !$past(cs, 2))
      else $error("cke fell too soon after a command");
   a_clock_hold: assert property ($fell(cke) |-> ck_en [*5])
      else $error("clock stopped too soon after cke low");
   a_osc_read_gap: assert property (take && req_op == OP_OSC_STOP |->
      ##1 !(take && (req_op == OP_OSC_READ || req_op == OP_OSC_START)) [*7])
      else $error("oscillator read or restart too soon");
   a_cbt_preamble: assert property ($fell(cke) && $past(dqs_oe) |->
      $past(dqs_oe, 2) && !$past(dqs_t) && !$past(dqs_t, 2) && $past(dqs_c) && $past(dqs_c, 2))
      else $error("strobe not parked before training entry");
   a_cbt_cmd_gap: assert property (take && req_op == OP_CBT_CMD |-> cbt_cnt == 4'h0)
      else $error("training commands too close");
   a_wl_quiet: assert property (wl_cnt > 6'h14 |-> !dqs_oe)
      else $error("strobe driven too soon in leveling");
   a_wl_first_edge: assert property (wl_cnt != 6'h00 |-> !dqs_t)
      else $error("strobe edge too soon in leveling");
endmodule

// >>> test/lpt_dev_model.sv
// lpt_dev_model: behavioural memory device answering write leveling
`timescale 1ns/1ns
module lpt_dev_model (
   // clock and pins
   input  wire logic core_clk,
   input  wire logic cke,
   input  wire logic dqs_t,
   input  wire logic dqs_oe,
   // answer speed
   input  wire logic slow,
   // sampled level back to host
   output logic      wl_fb
);
   logic lvl;
   initial wl_fb = 1'b0;
   // feedback line has no pull: it toggles while unused so stale data never passes
   always @(posedge core_clk) if (!dqs_oe) wl_fb <= !wl_fb;
   // answer lands within 20 ns of the strobe rise, fast or slow
   always @(posedge dqs_t) if (dqs_oe && cke) begin
      lvl = core_clk;
      #(slow ? 14 : 1) wl_fb = lvl;
   end
endmodule

// >>> test/tb_lpddr4x_training_powerdown_timing.sv
// tb_lpddr4x_training_powerdown_timing: directed timing scenarios for the sequencer
`timescale 1ns/1ns
module tb_lpddr4x_training_powerdown_timing;
   import lpt_pkg::*;
   // ----------------------------------------
   // signals
   // ----------------------------------------
   logic       core_clk, rst, req_valid, req_long, slow, req_ready, ck_en, cke, cs;
   logic       dqs_t, dqs_c, dqs_oe, wl_fb, wl_sample, wl_sample_valid, in_pd, in_cbt;
   logic [3:0] req_op;
   logic [5:0] req_ca, ca;
   logic       cke_q = 1'b1, oe_q = 1'b0, dt_q = 1'b0, armed = 1'b0, wl_last = 1'b0;
   int         failures = 0, n_checks = 0, cyc = 0, t_cs = -1000, t_fall = 0, t_rise = 0;
   int         t_oe = 0, t_edge = 0, n_wl = 0, lo_len = 0, t_tmp = 0;
   int         min_lo = 999, min_hi = 999, min_xp = 999, min_cc = 999;

   lpt_ctrl #(.ZQCAL_CYCLES(20)) dut (.core_clk(core_clk), .rst(rst), .req_valid(req_valid),
      .req_op(req_op), .req_long(req_long), .req_ca(req_ca), .req_ready(req_ready),
      .ck_en(ck_en), .cke(cke), .cs(cs), .ca(ca), .dqs_t(dqs_t), .dqs_c(dqs_c),
      .dqs_oe(dqs_oe), .wl_fb(wl_fb), .wl_sample(wl_sample),
      .wl_sample_valid(wl_sample_valid), .in_pd(in_pd), .in_cbt(in_cbt));
   lpt_dev_model dev (.core_clk(core_clk), .cke(cke), .dqs_t(dqs_t), .dqs_oe(dqs_oe),
      .slow(slow), .wl_fb(wl_fb));

   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end
   // ----------------------------------------
   // pin monitor
   // ----------------------------------------
   always @(posedge core_clk) begin
      cyc   <= cyc + 1;
      cke_q <= cke;
      oe_q  <= dqs_oe;
      dt_q  <= dqs_t;
      if (cs) t_cs <= cyc;
      if (cs && armed) begin
         armed <= 1'b0;
         if (cyc - t_rise < min_xp) min_xp <= cyc - t_rise;
      end
      if (cke_q && !cke) begin
         t_fall <= cyc;
         if (cyc - t_rise < min_hi) min_hi <= cyc - t_rise;
         if (cyc - t_cs < min_cc) min_cc <= cyc - t_cs;
      end
      if (!cke_q && cke) begin
         t_rise <= cyc;
         armed  <= 1'b1;
         lo_len <= cyc - t_fall;
         if (cyc - t_fall < min_lo) min_lo <= cyc - t_fall;
      end
      if (dqs_oe && !oe_q) t_oe <= cyc;
      if (dqs_t && !dt_q && t_edge < t_oe) t_edge <= cyc;
      if (wl_sample_valid) begin
         n_wl    <= n_wl + 1;
         wl_last <= wl_last & wl_sample;
      end
   end
   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // a minimum bound: yields the bound when met, the short value otherwise
   function automatic logic [31:0] atl(input int v, input int lo);
      return (v < lo) ? v : lo;
   endfunction
   task automatic send(input logic [3:0] op, input logic lng, output int t);
      int n;
      n = 0;
      req_op    <= op;
      req_long  <= lng;
      req_ca    <= {2'h0, op};
      req_valid <= 1'b1;
      @(posedge core_clk);
      while (req_ready !== 1'b1 && n < 3000) begin
         @(posedge core_clk);
         n++;
      end
      if (n >= 3000) failures++;
      t = cyc;
   endtask
   task automatic idle(input int n);
      req_valid <= 1'b0;
      repeat (n) @(posedge core_clk);
   endtask
   task automatic gap(input logic [3:0] a, input logic la, input logic [3:0] b, input int e);
      int t0, t1;
      send(a, la, t0);
      send(b, 1'b0, t1);
      idle(2);
      check(atl(t1 - t0, e), e);
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_pd(input logic [3:0] first, input int lo_min);
      int t;
      send(OP_PD_ENTER, 1'b0, t);
      send(OP_PD_EXIT, 1'b0, t);
      send(first, 1'b0, t);
      send(OP_PD_ENTER, 1'b0, t);
      check(in_pd, 1'b0);
      send(OP_PD_EXIT, 1'b0, t);
      send(OP_CMD, 1'b0, t);
      idle(8);
      check(atl(lo_len, lo_min), lo_min);
      check(atl(min_lo, 4), 4);
      check(atl(min_hi, 4), 4);
      check(atl(min_xp, 5), 5);
      check(atl(min_cc, 3), 3);
      check(ca, 6'h0f);
      $display("power-down test done");
   endtask
   task automatic t_cbt(input logic lng, input int x_min);
      int a, b, c, d, e;
      send(OP_CBT_ENTER, 1'b0, a);
      send(OP_CBT_CMD, 1'b0, b);
      check(in_cbt, 1'b1);
      send(OP_CBT_CMD, 1'b0, c);
      send(OP_CBT_EXIT, lng, d);
      send(OP_CMD, 1'b0, e);
      idle(4);
      check(atl(b - t_fall, 32), 32);
      check(atl(c - b, 14), 14);
      check(atl(e - d, x_min), x_min);
      check(in_cbt, 1'b0);
      $display("training test done");
   endtask
   task automatic t_wl(input logic s);
      int a, n0;
      slow <= s;
      n0 = n_wl;
      wl_last = 1'b1;
      send(OP_WL_ENTER, 1'b0, a);
      idle(150);
      check(atl(t_oe - a, 20), 20);
      check(atl(t_edge - a, 40), 40);
      check(atl(t_edge - t_oe, 20), 20);
      check(atl(n_wl - n0, 1), 1);
      check(wl_last, 1'b1);
      $display("leveling test done");
   endtask
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   task automatic results();
      $display("checks=%0d failures=%0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   initial begin
      #400000;
      failures++;
      results();
   end
   initial begin
      rst = 1'b1;
      req_valid = 1'b0;
      req_op = OP_NOP;
      req_long = 1'b0;
      req_ca = 6'h00;
      slow = 1'b0;
      repeat (8) @(posedge core_clk);
      rst <= 1'b0;
      @(posedge core_clk);
      check({cke, cs, dqs_oe, dqs_t, dqs_c, in_pd, in_cbt, req_ready}, 8'h89);
      t_pd(OP_CMD, 5);
      t_pd(OP_MRW, 10);
      t_pd(OP_ZQ_START, 5);
      gap(OP_ZQ_START, 1'b0, OP_ZQ_LATCH, 20);
      send(OP_ZQ_START, 1'b0, t_tmp);
      gap(OP_ZQ_LATCH, 1'b0, OP_CMD, 8);
      gap(OP_ZQ_RESET, 1'b0, OP_CMD, 7);
      gap(OP_OSC_STOP, 1'b0, OP_OSC_READ, 8);
      gap(OP_OSC_STOP, 1'b0, OP_OSC_START, 8);
      gap(OP_FSP, 1'b0, OP_CMD, 25);
      gap(OP_FSP, 1'b1, OP_CMD, 32);
      $display("delay test done");
      t_cbt(1'b0, 25);
      t_cbt(1'b1, 32);
      t_wl(1'b0);
      t_wl(1'b1);
      results();
   end
endmodule

bind lpt_ctrl lpt_ctrl_sva #(.ZQCAL_CYCLES(ZQCAL_CYCLES)) u_sva (.core_clk(core_clk),
   .rst(rst), .req_valid(req_valid), .req_op(req_op), .req_long(req_long), .req_ca(req_ca),
   .req_ready(req_ready), .ck_en(ck_en), .cke(cke), .cs(cs), .ca(ca), .dqs_t(dqs_t),
   .dqs_c(dqs_c), .dqs_oe(dqs_oe), .wl_fb(wl_fb), .wl_sample(wl_sample),
   .wl_sample_valid(wl_sample_valid), .in_pd(in_pd), .in_cbt(in_cbt));
